// [design/flash_program_port.v]
// Programming port of a code flash, parallel and serial.
// Assumes asynchronous pins; the clock is the oscillator.
// Notes on behaviour
// (RULE1) Writes time themselves.
// (RULE2) Address split over two ports.
// (RULE3) Mode pins pick operation.
// (RULE4) One short write pulse.
// (RULE5) Erase, locks: same pulse.
// (RULE6) Busy while cycle runs.
// (RULE7) Busy within a microsecond.
// (RULE8) Write ends in 50 us.
// (RULE9) Address, data held 48 periods.
// (RULE10) Data 48 periods after address.
// (RULE11) Drive, release within 48 periods.
// (RULE12) Enable echoes fixed byte.
// (RULE13) Serial erase clears array.
// (RULE14) Serial read returns byte.
// (RULE15) Serial write stores byte.
// (RULE16) Page: upper address, 256 bytes.
// (RULE17) Page bytes are data.
// (RULE18) Lock code picks level.
// (RULE19) Lock levels raised in order.
// (RULE20) Lock read: programmed reads one.
// (RULE21) Shift clock low first.
// (RULE22) Shift clock under one sixteenth.
// (RULE23) Instructions are four bytes.
// (RULE24) Polling inverts top bit.
// (RULE25) Sample rising, shift falling.
// (RULE26) Top bit first.
`timescale 1ns/1ns
`include "flash_program_map.vh"
module flash_program_port #(
    parameter [23:0] PAR_WR_CYCLES = `WR_PAR_CYC,
    parameter [23:0] SER_WR_CYCLES = `SWC_CYC,
    parameter [23:0] ERASE_CYCLES = `ERASE_CYC
) (
    // Clock, reset and clock enable.
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    // Parallel programming pins.
    input wire prog_reset,
    input wire code_fetch_n,
    input wire hv_supply_sel,
    input wire write_pulse_n,
    input wire mode_sel_a,
    input wire access_strobe,
    input wire mode_sel_b,
    input wire mode_sel_c,
    input wire mode_sel_d,
    input wire [4:0] addr_hi,
    input wire [7:0] addr_lo,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    output reg done_flag_out,
    // Serial programming pins.
    input wire sck,
    input wire mosi,
    output reg miso,
    output reg miso_oe_n,
    // Status.
    output reg prog_enabled,
    output reg lock_level_one,
    output reg lock_level_two,
    output reg lock_level_three
);
    // Engine states.
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_WRITE = 2'b01;
    localparam [1:0] ST_ERASE = 2'b10;
    // Kinds of serial answer byte.
    localparam [1:0] RS_ZERO = 2'b00;
    localparam [1:0] RS_ECHO = 2'b01;
    localparam [1:0] RS_MEM = 2'b10;
    localparam [1:0] RS_LOCK = 2'b11;

    // Synchronised pins.
    wire [31:0] clean;
    wire s_rst = clean[31];
    wire s_fetch_n = clean[30];
    wire s_hv = clean[29];
    wire s_wp_n = clean[28];
    wire [4:0] s_mode = clean[27:23];
    wire [12:0] s_addr = clean[22:10];
    wire [7:0] s_din = clean[9:2];
    wire s_sck = clean[1];
    wire s_mosi = clean[0];

    // All outside pins pass the three-flop filter.
    flash_pin_sync #(
        .WIDTH(32),
        .INIT(`PIN_INIT)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin({prog_reset, code_fetch_n, hv_supply_sel, write_pulse_n,
              mode_sel_a, access_strobe, mode_sel_b, mode_sel_c, mode_sel_d,
              addr_hi, addr_lo, data_in, sck, mosi}),
        .clean(clean)
    );

    // Engine state, timer and erase walk.
    reg [1:0] state;
    reg [23:0] timer;
    reg [12:0] walk;
    reg walk_done;
    // Previous strobe levels for edge detection.
    reg wp_q;
    reg sck_q;
    // Operation latched as the pulse falls.
    reg [12:0] par_waddr;
    reg [7:0] par_wdata;
    reg [4:0] par_mode;
    // Serial shift state.
    reg [7:0] rx;
    reg [7:0] tx;
    reg [2:0] bit_cnt;
    reg [1:0] byte_idx;
    reg [7:0] b1;
    reg [7:0] b2;
    reg [7:0] b3;
    // Page transfer state.
    reg page_on;
    reg page_wr;
    reg [4:0] page;
    reg [7:0] page_cnt;
    // Serial read address and pending answer.
    reg [12:0] ser_raddr;
    reg [1:0] resp_kind;
    reg load_pend;
    // Last serial byte write, for polling.
    reg [12:0] last_addr;
    reg [7:0] last_data;
    reg poll_arm;
    // Memory port.
    reg mem_we;
    reg [12:0] mem_addr;
    reg [7:0] mem_wdata;
    wire [7:0] mem_rdata;
    reg [7:0] resp;

    // Path selection from reset and code fetch.
    wire par_on = s_rst & ~s_fetch_n;
    wire ser_on = s_rst & s_fetch_n;
    wire idle = (state == ST_IDLE);
    wire wp_fall = wp_q & ~s_wp_n;
    wire wp_rise = ~wp_q & s_wp_n;
    wire sck_rise = ~sck_q & s_sck;
    wire sck_fall = sck_q & ~s_sck;
    // Operation starts as the pulse ends. [RULE1] [RULE3]
    wire par_go = wp_rise & par_on & s_hv & idle;
    wire par_wr = par_go & (par_mode == `MODE_WR_CODE);
    wire par_erase = par_go & (par_mode == `MODE_ERASE);
    wire par_l1 = par_go & (par_mode == `MODE_LOCK1);
    wire par_l2 = par_go & (par_mode == `MODE_LOCK2);
    wire par_l3 = par_go & (par_mode == `MODE_LOCK3);
    wire par_lock = par_l1 | par_l2 | par_l3;
    wire rd_code = par_on & (s_mode == `MODE_RD_CODE);
    wire rd_lock = par_on & (s_mode == `MODE_RD_LOCK);
    wire [2:0] locks = {lock_level_three, lock_level_two, lock_level_one};

    // Byte done on eighth rise, top bit first. [RULE25] [RULE26]
    wire [7:0] full = {rx[6:0], s_mosi};
    wire byte_done = sck_rise & ser_on & (bit_cnt == 3'd7);
    wire last_byte = byte_done & ~page_on & (byte_idx == 2'd3);
    wire ser_byte_wr = last_byte & prog_enabled & idle & (b1 == `OP_WRITE);
    wire ser_page_wr = byte_done & page_on & page_wr;
    wire ser_erase = last_byte & prog_enabled & idle & (b1 == `OP_ENABLE) & (b2[7:5] == `ERASE_B2);
    wire ser_lock = last_byte & prog_enabled & idle & (b1 == `OP_ENABLE) & (b2[7:2] == `LOCK_B2);
    wire page_start = byte_done & ~page_on & (byte_idx == 2'd1) & prog_enabled &
        ((b1 == `OP_PAGE_RD) | (b1 == `OP_PAGE_WR));
    wire wr_req = par_wr | ser_byte_wr | ser_page_wr;
    // Address from both ports. [RULE2]
    wire [12:0] wr_addr = par_wr ? par_waddr : (page_on ? {page, page_cnt} : {b2[4:0], b3});
    wire [7:0] wr_data = par_wr ? par_wdata : full;

    // Erase walk first, then a write, else a read.
    always @* begin
        mem_we = 1'b0;
        mem_addr = s_fetch_n ? ser_raddr : s_addr;
        mem_wdata = wr_data;
        if (state == ST_ERASE) begin
            mem_we = 1'b1;
            mem_addr = walk;
            mem_wdata = `ERASED;
        end else if (wr_req) begin
            mem_we = 1'b1;
            mem_addr = wr_addr;
        end
    end

    flash_code_mem #(
        .AW(13),
        .DW(8)
    ) u_mem (
        .clock(clock),
        .clk_en(clk_en),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // Answer for the fourth or next page byte.
    always @* begin
        case (resp_kind)
            RS_ECHO: resp = `ECHO_BYTE; // [RULE12]
            RS_LOCK: resp = {3'b000, locks, 2'b00}; // [RULE20]
            RS_MEM: begin
                // Polling the pending byte inverts its top bit. [RULE24]
                if (poll_arm && !idle && ser_raddr == last_addr) begin
                    resp = {~last_data[7], last_data[6:0]};
                end else begin
                    resp = mem_rdata; // [RULE14]
                end
            end
            default: resp = 8'h00;
        endcase
    end

    // Self-timed engine for writes, lock writes and erase.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            timer <= 24'h000000;
            walk <= 13'h0000;
            walk_done <= 1'b0;
        end else if (clk_en) begin
            case (state)
                ST_IDLE: begin
                    if (par_erase || ser_erase) begin
                        // Whole array walks to the erased value. [RULE13]
                        state <= ST_ERASE;
                        timer <= ERASE_CYCLES - 24'h000001;
                        walk <= 13'h0000;
                        walk_done <= 1'b0;
                    end else if (par_wr || par_lock) begin
                        // Ends inside the longest write time. [RULE1] [RULE8]
                        state <= ST_WRITE;
                        timer <= PAR_WR_CYCLES - 24'h000001;
                    end else if (ser_byte_wr || ser_lock) begin
                        state <= ST_WRITE;
                        timer <= SER_WR_CYCLES - 24'h000001;
                    end
                end
                ST_WRITE: begin
                    if (timer == 24'h000000) begin
                        state <= ST_IDLE;
                    end else begin
                        timer <= timer - 24'h000001;
                    end
                end
                ST_ERASE: begin
                    if (walk == 13'h1fff) begin
                        walk_done <= 1'b1;
                    end else begin
                        walk <= walk + 13'h0001;
                    end
                    if (timer != 24'h000000) begin
                        timer <= timer - 24'h000001;
                    end else if (walk_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Lock bits: set by lock writes, cleared by erase. [RULE18]
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_level_one <= 1'b0;
            lock_level_two <= 1'b0;
            lock_level_three <= 1'b0;
        end else if (clk_en) begin
            if (par_erase || ser_erase) begin
                lock_level_one <= 1'b0;
                lock_level_two <= 1'b0;
                lock_level_three <= 1'b0;
            end else begin
                if (par_l1 || (ser_lock && b2[1:0] == 2'b01)) begin
                    lock_level_one <= 1'b1;
                end
                if (par_l2 || (ser_lock && b2[1:0] == 2'b10)) begin
                    lock_level_two <= 1'b1;
                end
                if (par_l3 || (ser_lock && b2[1:0] == 2'b11)) begin
                    lock_level_three <= 1'b1;
                end
            end
        end
    end

    // Parallel latch and read drive.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= 1'b1;
            par_waddr <= 13'h0000;
            par_wdata <= 8'h00;
            par_mode <= 5'h00;
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
            done_flag_out <= 1'b1;
        end else if (clk_en) begin
            wp_q <= s_wp_n;
            if (wp_fall) begin
                par_waddr <= s_addr; // [RULE2]
                par_wdata <= s_din;
                par_mode <= s_mode;
            end
            // Read data follows within a few cycles. [RULE10] [RULE11]
            data_oe_n <= ~(rd_code | rd_lock);
            data_out <= rd_lock ? {3'b000, locks, 2'b00} : mem_rdata;
            // Busy from the cycle after the pulse. [RULE6] [RULE7]
            done_flag_out <= idle & ~par_go;
        end
    end

    // Serial path: shift in on rising, answer on falling edges.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
            rx <= 8'h00;
            tx <= 8'h00;
            bit_cnt <= 3'd0;
            byte_idx <= 2'd0;
            b1 <= 8'h00;
            b2 <= 8'h00;
            b3 <= 8'h00;
            page_on <= 1'b0;
            page_wr <= 1'b0;
            page <= 5'h00;
            page_cnt <= 8'h00;
            ser_raddr <= 13'h0000;
            resp_kind <= RS_ZERO;
            load_pend <= 1'b0;
            miso <= 1'b0;
            miso_oe_n <= 1'b1;
            prog_enabled <= 1'b0;
        end else if (clk_en) begin
            sck_q <= s_sck;
            miso_oe_n <= ~ser_on;
            if (!ser_on) begin
                // Leaving serial mode drops a partial instruction.
                bit_cnt <= 3'd0;
                byte_idx <= 2'd0;
                page_on <= 1'b0;
                load_pend <= 1'b0;
                if (!s_rst) begin
                    prog_enabled <= 1'b0;
                end
            end else begin
                if (sck_rise) begin
                    rx <= full; // [RULE25]
                    bit_cnt <= bit_cnt + 3'd1;
                end
                if (byte_done && page_on) begin
                    // Data until the page has passed. [RULE16] [RULE17]
                    page_cnt <= page_cnt + 8'h01;
                    ser_raddr <= {page, page_cnt + 8'h01};
                    if (page_cnt == `PAGE_LAST) begin
                        page_on <= 1'b0;
                        byte_idx <= 2'd0;
                    end else begin
                        load_pend <= ~page_wr;
                        resp_kind <= RS_MEM;
                    end
                end else if (page_start) begin
                    page_on <= 1'b1;
                    page_wr <= (b1 == `OP_PAGE_WR);
                    page <= full[4:0];
                    page_cnt <= 8'h00;
                    byte_idx <= 2'd0;
                    ser_raddr <= {full[4:0], 8'h00};
                    load_pend <= (b1 == `OP_PAGE_RD);
                    resp_kind <= RS_MEM;
                end else if (byte_done) begin
                    // Four bytes make one instruction. [RULE23]
                    byte_idx <= byte_idx + 2'd1;
                    if (byte_idx == 2'd0) begin
                        b1 <= full;
                    end else if (byte_idx == 2'd1) begin
                        b2 <= full;
                    end else if (byte_idx == 2'd2) begin
                        b3 <= full;
                        ser_raddr <= {b2[4:0], full};
                        load_pend <= 1'b1;
                        if (b1 == `OP_ENABLE && b2 == `OP_ENABLE2) begin
                            resp_kind <= RS_ECHO;
                        end else if (b1 == `OP_READ && prog_enabled) begin
                            resp_kind <= RS_MEM;
                        end else if (b1 == `OP_LOCK_RD && prog_enabled) begin
                            resp_kind <= RS_LOCK;
                        end else begin
                            resp_kind <= RS_ZERO;
                        end
                    end else if (b1 == `OP_ENABLE && b2 == `OP_ENABLE2) begin
                        prog_enabled <= 1'b1; // [RULE12]
                    end
                end
                if (sck_fall) begin
                    // Answer out top bit first on falls. [RULE26]
                    if (load_pend) begin
                        tx <= resp;
                        miso <= resp[7];
                        load_pend <= 1'b0;
                    end else begin
                        tx <= {tx[6:0], 1'b0};
                        miso <= tx[6];
                    end
                end
            end
        end
    end

    // Last serial byte write, watched for polling. [RULE15]
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_addr <= 13'h0000;
            last_data <= 8'h00;
            poll_arm <= 1'b0;
        end else if (clk_en) begin
            if (ser_byte_wr) begin
                last_addr <= wr_addr;
                last_data <= wr_data;
                poll_arm <= 1'b1;
            end else if (par_go || ser_erase || ser_lock) begin
                poll_arm <= 1'b0;
            end
        end
    end
endmodule

// [design/flash_program_map.vh]
// Timing counts, opcodes and mode codes of the programming port.
// Assumes a 50 ns clock; included by bare name.
`ifndef FLASH_PROGRAM_MAP_VH
`define FLASH_PROGRAM_MAP_VH

// System clock period in nanoseconds.
`define CLOCK_NS 50
// Longest parallel byte write, as cycles.
`define WR_PAR_US 50
`define WR_PAR_CYC ((`WR_PAR_US * 1000) / `CLOCK_NS)
// Serial byte write: 64 periods plus 400 us.
`define SWC_OSC 64
`define SWC_US 400
`define SWC_CYC (`SWC_OSC + (`SWC_US * 1000) / `CLOCK_NS)
// Chip erase time in milliseconds, as cycles.
`define ERASE_MS 500
`define ERASE_CYC ((`ERASE_MS * 1000000) / `CLOCK_NS)

// Serial instruction bytes.
`define OP_ENABLE 8'hac
`define OP_ENABLE2 8'h53
`define ECHO_BYTE 8'h69
`define OP_READ 8'h20
`define OP_WRITE 8'h40
`define OP_PAGE_RD 8'h30
`define OP_PAGE_WR 8'h50
`define OP_LOCK_RD 8'h24
`define ERASE_B2 3'b100
`define LOCK_B2 6'b111000

// Parallel modes as {a, strobe, b, c, d} select pins.
`define MODE_WR_CODE 5'h0f
`define MODE_RD_CODE 5'h03
`define MODE_LOCK1 5'h1f
`define MODE_LOCK2 5'h1c
`define MODE_LOCK3 5'h16
`define MODE_RD_LOCK 5'h1a
`define MODE_ERASE 5'h14

// Value of an erased byte and the last byte of a page.
`define ERASED 8'hff
`define PAGE_LAST 8'hff
// Filter reset value: code fetch and write pulse high, all other pins low.
`define PIN_INIT 32'h50000000

`endif

// [design/flash_pin_sync.v]
// Three-flop filter for pins from outside the clock domain.
// A bit follows once its second and third flops agree.
`timescale 1ns/1ns
module flash_pin_sync #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // Clock, reset and clock enable.
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    // Raw pins and their filtered value.
    input wire [WIDTH-1:0] pin,
    output wire [WIDTH-1:0] clean
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : bit_sync
            // Three flops in a row and the accepted value.
            reg s1, s2, s3, hold;
            // The first flop feeds the second only; the filter looks at two and three.
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    s1 <= INIT[i];
                    s2 <= INIT[i];
                    s3 <= INIT[i];
                    hold <= INIT[i];
                end else if (clk_en) begin
                    s1 <= pin[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        hold <= s3;
                    end
                end
            end
            assign clean[i] = hold;
        end
    endgenerate
endmodule

// [design/flash_code_mem.v]
// Code array of the flash: one write port, read data from a register.
// Assumes the caller shares the one address.
`timescale 1ns/1ns
module flash_code_mem #(
    parameter AW = 13,
    parameter DW = 8
) (
    // Clock and clock enable.
    input wire clock,
    input wire clk_en,
    // Access port.
    input wire we,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output reg [DW-1:0] rdata
);
    // Storage cells.
    reg [DW-1:0] cells [0:(1<<AW)-1];

    // Write when asked; always register the addressed cell.
    always @(posedge clock) begin
        if (clk_en) begin
            if (we) begin
                cells[addr] <= wdata;
            end
            rdata <= cells[addr];
        end
    end
endmodule

// [test/flash_program_port_monitor.sv]
// Checker of the flash programming port, bound to its top module.
// Assumes pins stay put for several clocks.
`timescale 1ns/1ns
`include "flash_program_map.vh"
module flash_program_port_monitor (
    // Clock and reset.
    input wire clock,
    input wire rst_n,
    // Pins watched.
    input wire prog_reset,
    input wire code_fetch_n,
    input wire hv_supply_sel,
    input wire write_pulse_n,
    input wire mode_sel_a,
    input wire access_strobe,
    input wire mode_sel_b,
    input wire mode_sel_c,
    input wire mode_sel_d,
    input wire data_oe_n,
    input wire done_flag_out,
    input wire sck,
    input wire miso,
    input wire prog_enabled
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Mode code and parallel path selection.
    wire [4:0] mode = {mode_sel_a, access_strobe, mode_sel_b, mode_sel_c, mode_sel_d};
    wire par = prog_reset && !code_fetch_n;
    property p_busy_soon;
        $rose(write_pulse_n) && par && hv_supply_sel && done_flag_out && mode == `MODE_WR_CODE
        |-> ##[1:20] !done_flag_out;
    endproperty
    a_busy_soon: assert property (p_busy_soon) else $error("busy too late");
    property p_wr_end;
        $fell(done_flag_out) && par && mode == `MODE_WR_CODE |-> ##[1:1000] done_flag_out;
    endproperty
    a_wr_end: assert property (p_wr_end) else $error("write too long");
    property p_busy_hold;
        $fell(done_flag_out) |-> !done_flag_out [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
    property p_no_hv;
        $rose(write_pulse_n) && !hv_supply_sel && done_flag_out |-> done_flag_out [*8];
    endproperty
    a_no_hv: assert property (p_no_hv) else $error("write without supply");
    property p_rd_on;
        $fell(access_strobe) && par && mode == `MODE_RD_CODE |-> ##[1:48] !data_oe_n;
    endproperty
    a_rd_on: assert property (p_rd_on) else $error("read data late");
    property p_rd_off;
        $rose(access_strobe) && par && mode != `MODE_RD_LOCK |-> ##[1:48] data_oe_n;
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("bus not released");
    property p_miso_edge;
        $changed(miso) |-> !sck;
    endproperty
    a_miso_edge: assert property (p_miso_edge) else $error("miso moved with clock high");
    property p_en_drop;
        !prog_reset [*8] |-> !prog_enabled;
    endproperty
    a_en_drop: assert property (p_en_drop) else $error("enable kept");
endmodule
bind flash_program_port flash_program_port_monitor mon (.*);

// [test/flash_programmer_model.sv]
// Serial side of an external programmer: shift clock and data out.
// Assumes it is only called while the serial path is selected.
`timescale 1ns/1ns
module flash_programmer_model (
    // System clock.
    input wire clock,
    // Serial lines.
    output reg sck,
    output reg mosi,
    input wire miso
);
    // Shift clock rests low between frames.
    initial begin
        sck = 1'b0;
        mosi = 1'b1;
    end
    // One byte, top bit first, eight clocks or more per phase.
    task shift_byte(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                @(negedge clock) mosi = tx[i];
                repeat (8) @(negedge clock);
                sck = 1'b1;
                rx[i] = miso;
                repeat (8) @(negedge clock);
                sck = 1'b0;
                mosi = ~mosi;
            end
        end
    endtask
endmodule

// [test/tb_flash_program_port.sv]
// Self-checking bench of the flash programming port, both entry paths.
// Assumes the bound checker and the programmer model.
`timescale 1ns/1ns
`include "flash_program_map.vh"
module tb_flash_program_port;
    reg clock = 1'b0, rst_n = 1'b0, prog_reset = 1'b0, cf_n = 1'b0, hv = 1'b1, wp_n = 1'b1;
    reg [4:0] mode = 5'h1f, hi;
    reg [12:0] a = 13'h0000;
    reg [7:0] din = 8'h00, d, rx;
    reg [7:0] mem [0:8191];
    reg [7:0] q [$];
    reg [2:0] lk = 3'b000;
    reg [1:0] bb;
    wire [7:0] dout;
    wire oe_n, done, sck, mosi, miso, miso_oe_n, en, l1, l2, l3;
    integer fails = 0, samples_checked = 0, i, j, busy;
    flash_program_port #(.PAR_WR_CYCLES(24'd20), .SER_WR_CYCLES(24'd700), .ERASE_CYCLES(24'd8200)) dut (
        .clock, .rst_n, .clk_en(1'b1), .prog_reset, .code_fetch_n(cf_n),
        .hv_supply_sel(hv), .write_pulse_n(wp_n), .mode_sel_a(mode[4]), .access_strobe(mode[3]),
        .mode_sel_b(mode[2]), .mode_sel_c(mode[1]), .mode_sel_d(mode[0]), .addr_hi(a[12:8]),
        .addr_lo(a[7:0]), .data_in(din), .data_out(dout), .data_oe_n(oe_n), .done_flag_out(done),
        .sck, .mosi, .miso, .miso_oe_n, .prog_enabled(en),
        .lock_level_one(l1), .lock_level_two(l2), .lock_level_three(l3));
    flash_programmer_model pm (.clock, .sck, .mosi, .miso);
    always #25 clock = ~clock;
    task chk(input string n, input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("Error %0s expected %h seen %h", n, exp, seen);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task wt(input integer n);
        repeat (n) @(negedge clock);
    endtask
    // One parallel pulse; counts busy cycles.
    task par_op(input [4:0] m, input [12:0] ad, input [7:0] dt, input h, input integer lim);
        integer n;
        begin
            mode = m;
            a = ad;
            din = dt;
            hv = h;
            wt(50);
            wp_n = 1'b0;
            wt(5);
            wp_n = 1'b1;
            n = 0;
            busy = 0;
            while (n < lim && (n < 60 || done !== 1'b1)) begin
                @(negedge clock);
                n = n + 1;
                if (done === 1'b0) busy = busy + 1;
            end
            if (n >= lim) begin
                fails = fails + 1;
                print_verdict;
            end
        end
    endtask
    // Parallel read, then the bus must float again.
    task par_rd(input [4:0] m, input [12:0] ad, input [7:0] exp);
        begin
            mode = m;
            a = ad;
            wt(48);
            chk("oe", {7'h00, oe_n}, 8'h00);
            chk("rd", dout, exp);
            mode = 5'h1f;
            wt(48);
            chk("float", {7'h00, oe_n}, 8'h01);
        end
    endtask
    task ser(input [31:0] c, output [7:0] r);
        integer k;
        begin
            for (k = 3; k >= 0; k = k - 1)
                pm.shift_byte(c[8*k +: 8], r);
        end
    endtask
    initial begin
        i = $urandom(32'h676a);
        wt(12);
        rst_n = 1'b1;
        prog_reset = 1'b1;
        wt(8);
        for (j = 0; j < 3; j = j + 1) begin
            a = $urandom;
            d = $urandom;
            mem[a] = d;
            par_op(`MODE_WR_CODE, a, d, 1'b1, 2000);
            chk("busy", {7'h00, busy > 0 && busy <= 1000}, 8'h01);
            par_rd(`MODE_RD_CODE, a, mem[a]);
        end
        par_op(`MODE_WR_CODE, a, ~d, 1'b0, 2000);
        chk("refused", busy[7:0], 8'h00);
        par_rd(`MODE_RD_CODE, a, d);
        for (j = 0; j < 3; j = j + 1) begin
            lk[j] = 1'b1;
            par_op(j == 0 ? `MODE_LOCK1 : j == 1 ? `MODE_LOCK2 : `MODE_LOCK3, a, 8'h00, 1'b1, 2000);
            par_rd(`MODE_RD_LOCK, a, {3'b000, lk, 2'b00});
            chk("locks", {5'h00, l3, l2, l1}, {5'h00, lk});
        end
        par_op(`MODE_ERASE, a, 8'h00, 1'b1, 10000);
        lk = 3'b000;
        par_rd(`MODE_RD_CODE, a, `ERASED);
        par_rd(`MODE_RD_LOCK, a, 8'h00);
        $display("parallel test done");
        cf_n = 1'b1;
        wt(64);
        chk("miso oe", {7'h00, miso_oe_n}, 8'h00);
        ser({`OP_READ, 3'b000, a, 8'h00}, rx);
        chk("locked out", rx, 8'h00);
        ser({`OP_ENABLE, `OP_ENABLE2, 16'h0000}, rx);
        chk("echo", rx, `ECHO_BYTE);
        chk("enabled", {7'h00, en}, 8'h01);
        d = $urandom;
        ser({`OP_WRITE, 3'b000, a, d}, rx);
        ser({`OP_READ, 3'b000, a, 8'h00}, rx);
        chk("poll", rx, {~d[7], d[6:0]});
        wt(750);
        ser({`OP_READ, 3'b000, a, 8'h00}, rx);
        chk("ser rd", rx, d);
        for (j = 0; j < 3; j = j + 1) begin
            bb = j + 1;
            lk[j] = 1'b1;
            ser({`OP_ENABLE, `LOCK_B2, bb, 16'h0000}, rx);
            wt(750);
            ser({`OP_LOCK_RD, 24'h000000}, rx);
            chk("ser lock", rx, {3'b000, lk, 2'b00});
            chk("ser locks", {5'h00, l3, l2, l1}, {5'h00, lk});
        end
        ser({`OP_ENABLE, `ERASE_B2, 21'h000000}, rx);
        wt(8300);
        ser({`OP_READ, 3'b000, a, 8'h00}, rx);
        chk("ser erase", rx, `ERASED);
        $display("serial byte test done");
        hi = $urandom;
        for (i = 0; i < 2; i = i + 1) begin
            pm.shift_byte(i ? `OP_PAGE_RD : `OP_PAGE_WR, rx);
            pm.shift_byte({3'b000, hi}, rx);
            for (j = 0; j < 256; j = j + 1) begin
                if (i == 0) q.push_back($urandom);
                pm.shift_byte(i ? 8'h00 : q[j], rx);
                if (i) chk("page", rx, q[j]);
            end
        end
        ser({`OP_READ, 3'b000, hi, `PAGE_LAST, 8'h00}, rx);
        chk("after page", rx, q[255]);
        $display("page test done");
        prog_reset = 1'b0;
        wt(10);
        chk("disabled", {7'h00, en}, 8'h00);
        print_verdict;
    end
endmodule
